// ---- core/tpmcc_pkg.sv ----
// Purpose: Shared constants and types for the timer channel mode control block.
// Assumes: AHB-Lite register access, 32-bit data, one aligned word per register.
// Notes:   Offsets and bit positions are used by the core and by the bench.
package tpmcc_pkg;

  // Register byte offsets
  localparam logic [7:0] CSC_OFF = 8'h00;
  localparam logic [7:0] CTL_OFF = 8'h04;

  // channel_status_control field positions
  localparam int FLAG_BIT = 7;
  localparam int IE_BIT   = 6;
  localparam int MSB_BIT  = 5;
  localparam int MSA_BIT  = 4;
  localparam int ELSB_BIT = 3;
  localparam int ELSA_BIT = 2;

  // Module control field position
  localparam int CPWM_BIT = 0;

  // Values after reset
  localparam logic [7:0] CSC_RST = 8'h00;
  localparam logic [7:0] CTL_RST = 8'h00;

  // Pin synchroniser depth
  localparam int SYNC_STAGES = 3;

  // Edge/level select encodings
  localparam logic [1:0] ELS_OFF  = 2'h0;
  localparam logic [1:0] ELS_RISE = 2'h1;
  localparam logic [1:0] ELS_FALL = 2'h2;
  localparam logic [1:0] ELS_BOTH = 2'h3;
  localparam logic [1:0] ELS_TGL  = 2'h1;
  localparam logic [1:0] ELS_CLR  = 2'h2;
  localparam logic [1:0] ELS_SET  = 2'h3;

  typedef enum logic [1:0] {
    M_IC,
    M_OC,
    M_EPWM,
    M_CPWM
  } tpmcc_mode_t;

  // Channel mode from center select and the two mode-select bits
  function automatic tpmcc_mode_t tpmcc_mode_dec(input logic cpwm, input logic msb, input logic msa);
    if (cpwm)
      return M_CPWM;
    else if (msb)
      return M_EPWM;
    else if (msa)
      return M_OC;
    else
      return M_IC;
  endfunction : tpmcc_mode_dec

endpackage : tpmcc_pkg

// ---- core/tpmcc_pin_sync.sv ----
// Purpose: Synchronise the channel pin and report filtered edges.
// Assumes: Pin is asynchronous to hclk.
// Notes:   Level accepted only when stages two and three agree.
`timescale 1ns/1ps
module tpmcc_pin_sync
  import tpmcc_pkg::*;
(
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Pin and edges
  input  wire logic pin_in,
  output logic      rise,
  output logic      fall
);

  typedef struct packed {
    logic [SYNC_STAGES-1:0] s;
    logic                   lvl;
    logic                   init;
    logic                   rise;
    logic                   fall;
  } tpmcc_sync_t;

  tpmcc_sync_t q;
  tpmcc_sync_t d;
  logic        agree;

  // Stage 0 feeds only stage 1
  assign agree = (q.s[1] == q.s[2]);

  always_comb begin
    d      = q;
    d.s    = {q.s[1:0], pin_in};
    d.rise = 1'b0;
    d.fall = 1'b0;
    if (agree) begin
      // Reset zeros form the first settled level, taken without an edge, so a pin high at reset gives a rise
      d.init = 1'b1;
      d.lvl  = q.s[2];
      d.rise = q.init && q.s[2] && !q.lvl;
      d.fall = q.init && !q.s[2] && q.lvl;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      q <= '0;
    else
      q <= d;
  end

  assign rise = q.rise;
  assign fall = q.fall;

endmodule : tpmcc_pin_sync

// ---- core/tpmcc_channel.sv ----
// Purpose: Channel mode, pin and event flag control of a 16-bit timer/PWM.
// Assumes: Counter, modulo and channel value come from the shared counter logic.
// Notes:   AHB-Lite slave with zero wait states.
// Functional notes
// [RQ1] Capture mode: active pin edge sets flag
// [RQ2] Compare/PWM modes: counter match sets flag
// [RQ3] PWM at 0% or 100% never sets flag
// [RQ4] Interrupt request while flag and enable set
// [RQ5] Flag clears by read-set then write-zero
// [RQ6] New event restarts clear sequence, flag stays
// [RQ7] Reset clears flag; writing one no effect
// [RQ8] Interrupt enable read/write, reset to zero
// [RQ9] Mode B set gives edge PWM
// [RQ10] Mode pair 00 capture, 01 compare
// [RQ11] Software keeps pin stable before capture
// [RQ12] Edge/level 00 releases the pin
// [RQ13] Capture on rising, falling or both
// [RQ14] Compare: none, toggle, clear, set
// [RQ15] Edge PWM high-true or low-true pulses
// [RQ16] Center select forces center PWM per polarity
// [RQ17] Center select switches counter to up/down
// [RQ18] Down-count match drives complementary level
`timescale 1ns/1ps
module tpmcc_channel
  import tpmcc_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int CNT_W  = 16
) (
  // Clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic [31:0]            hrdata,
  output logic                   hresp,
  // Shared counter
  input  wire logic [CNT_W-1:0]  cnt_value,
  input  wire logic [CNT_W-1:0]  cnt_mod,
  input  wire logic              cnt_tick,
  input  wire logic              cnt_down,
  input  wire logic [CNT_W-1:0]  ch_value,
  output logic                   center_pwm,
  // Channel pin
  input  wire logic              pin_in,
  output logic                   pin_out,
  output logic                   pin_oe,
  // Interrupt request
  output logic                   irq
);

  typedef struct packed {
    logic              flag;
    logic              ie;
    logic              msb;
    logic              msa;
    logic              elsb;
    logic              elsa;
    logic              cpwm;
    logic              arm;
    logic              pin;
    logic              oe;
    logic              dv;
    logic              dwr;
    logic [ADDR_W-1:0] dadr;
    logic [7:0]        rdata;
  } tpmcc_state_t;

  tpmcc_state_t q;
  tpmcc_state_t d;
  tpmcc_mode_t  mode;
  tpmcc_mode_t  mode_n;
  logic [1:0]   els;
  logic         take;
  logic         wr_csc;
  logic         wr_ctl;
  logic         rise;
  logic         fall;
  logic         cap_ev;
  logic         hit;
  logic         ext;
  logic         cmp_ev;
  logic         wrap;
  logic         ev;
  logic         clr;
  logic         rd_csc;

  tpmcc_pin_sync u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin_in  (pin_in),
    .rise    (rise),
    .fall    (fall)
  );

  assign mode   = tpmcc_mode_dec(q.cpwm, q.msb, q.msa); // RQ9 RQ10 RQ17
  assign els    = {q.elsb, q.elsa};
  assign take   = hsel && hready && htrans[1];
  assign wr_csc = q.dv && q.dwr && (q.dadr == ADDR_W'(CSC_OFF));
  assign wr_ctl = q.dv && q.dwr && (q.dadr == ADDR_W'(CTL_OFF));
  // Read of the status register, seen by the clear-sequence checks
  assign rd_csc = take && !hwrite && (haddr == ADDR_W'(CSC_OFF));

  // Capture edges by polarity
  assign cap_ev = (mode == M_IC) && ((q.elsa && rise) || (q.elsb && fall)); // RQ1 RQ13

  // Match counts once per counter step, so a stopped counter cannot refire
  assign hit  = cnt_tick && (cnt_value == ch_value);
  assign wrap = cnt_tick && (cnt_value == '0);
  // Zero, or a value beyond a set modulo, means 0% or 100% duty: no match event
  assign ext  = (ch_value == '0) || ((cnt_mod != '0) && (ch_value > cnt_mod));

  always_comb begin
    cmp_ev = 1'b0;
    if (mode == M_OC)
      cmp_ev = hit; // RQ2
    else if (mode != M_IC)
      cmp_ev = hit && !ext; // RQ2 RQ3
  end

  assign ev  = cap_ev || cmp_ev;
  // A status register write or a new event disarms, so a stale read can never clear a later event
  assign clr = wr_csc && !hwdata[FLAG_BIT] && q.arm; // RQ5

  always_comb begin
    d      = q;
    mode_n = M_IC;

    // Bus address phase
    d.dv   = take;
    d.dwr  = hwrite;
    d.dadr = haddr;

    // Register writes
    if (wr_csc) begin
      d.ie   = hwdata[IE_BIT]; // RQ8
      d.msb  = hwdata[MSB_BIT];
      d.msa  = hwdata[MSA_BIT];
      d.elsb = hwdata[ELSB_BIT];
      d.elsa = hwdata[ELSA_BIT];
      d.arm  = 1'b0;
    end
    if (wr_ctl)
      d.cpwm = hwdata[CPWM_BIT]; // RQ17

    // Flag: writing one is ignored; an event beats a clear
    if (clr)
      d.flag = 1'b0; // RQ5 RQ7
    if (ev) begin
      d.flag = 1'b1; // RQ1 RQ2 RQ6
      d.arm  = 1'b0; // RQ6
    end

    // Pin level per mode
    unique case (mode)
      M_IC: begin
        d.pin = q.pin;
      end
      M_OC: begin
        if (hit) begin
          unique case (els)
            ELS_OFF: d.pin = q.pin;
            ELS_TGL: d.pin = !q.pin; // RQ14
            ELS_CLR: d.pin = 1'b0; // RQ14
            ELS_SET: d.pin = 1'b1; // RQ14
          endcase
        end
      end
      M_EPWM: begin
        // Match wins over wrap so a zero value gives 0% duty
        if (hit)
          d.pin = q.elsa; // RQ15
        else if (wrap)
          d.pin = !q.elsa; // RQ15
      end
      M_CPWM: begin
        if (hit && !cnt_down)
          d.pin = q.elsa; // RQ16
        else if (hit && cnt_down)
          d.pin = !q.elsa; // RQ18
      end
    endcase

    // Pin released when polarity is off or the pin is an input
    mode_n = tpmcc_mode_dec(d.cpwm, d.msb, d.msa);
    d.oe   = ({d.elsb, d.elsa} != ELS_OFF) && (mode_n != M_IC); // RQ12

    // Read data built from next state so a write just before is visible
    if (take && !hwrite) begin
      if (haddr == ADDR_W'(CSC_OFF)) begin
        d.rdata = {d.flag, d.ie, d.msb, d.msa, d.elsb, d.elsa, 2'b00};
        if (d.flag)
          d.arm = 1'b1; // RQ5
      end else if (haddr == ADDR_W'(CTL_OFF)) begin
        d.rdata = CTL_RST;
        d.rdata[CPWM_BIT] = d.cpwm;
      end else begin
        d.rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      q <= '0; // RQ7 RQ8
    else
      q <= d;
  end

  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign hrdata     = {24'h000000, q.rdata};
  assign center_pwm = q.cpwm; // RQ17
  assign pin_out    = q.pin;
  assign pin_oe     = q.oe;
  assign irq        = q.flag && q.ie; // RQ4

  // Checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  flag_on_capture_a: // RQ1
    assert property (cap_ev |=> q.flag)
    else $error("capture edge did not set flag");

  flag_on_match_a: // RQ2
    assert property ((mode == M_OC) && hit |=> q.flag)
    else $error("compare match did not set flag");

  no_flag_extreme_a: // RQ3
    assert property ((mode inside {M_EPWM, M_CPWM}) && ext && !q.flag |=> !q.flag)
    else $error("flag set at 0 or 100 percent duty");

  irq_follow_a: // RQ4
    assert property (wr_csc && hwdata[IE_BIT] && (ev || (q.flag && !clr)) |=> irq)
    else $error("interrupt request missing with flag and enable set");

  clear_seq_a: // RQ5
    assert property ($fell(q.flag) |-> $past(q.arm) && $past(wr_csc) && !$past(hwdata[FLAG_BIT]))
    else $error("flag cleared without read-then-write sequence");

  no_lost_event_a: // RQ6
    assert property (ev && clr |=> q.flag && (!q.arm || $past(rd_csc)))
    else $error("event lost during clear");

  write_one_a: // RQ7
    assert property (wr_csc && hwdata[FLAG_BIT] && !ev |=> q.flag == $past(q.flag))
    else $error("writing one changed the flag");

  ie_write_a: // RQ8
    assert property (wr_csc |=> q.ie == $past(hwdata[IE_BIT]))
    else $error("interrupt enable not written");

  edge_pwm_sel_a: // RQ9
    assert property (!q.cpwm && q.msb && hit |=> pin_out == $past(q.elsa))
    else $error("edge PWM not selected");

  pin_release_a: // RQ12
    assert property (wr_csc && (hwdata[ELSB_BIT:ELSA_BIT] == ELS_OFF) ##1 !wr_csc |-> !pin_oe [*2])
    else $error("pin driven with edge/level off");

  rise_only_a: // RQ13
    assert property ((mode == M_IC) && (els == ELS_RISE) && fall && !rise |-> !cap_ev)
    else $error("falling edge captured in rising mode");

  oc_toggle_a: // RQ14
    assert property ((mode == M_OC) && (els == ELS_TGL) && hit |=> pin_out != $past(pin_out))
    else $error("compare toggle missing");

  epwm_high_a: // RQ15
    assert property ((mode == M_EPWM) && (els == ELS_FALL) && hit |=> !pin_out)
    else $error("edge PWM did not clear on match");

  cpwm_up_a: // RQ16
    assert property ((mode == M_CPWM) && hit && !cnt_down |=> pin_out == $past(q.elsa))
    else $error("center PWM up-count level wrong");

  cpwm_force_a: // RQ17
    assert property (wr_ctl && hwdata[CPWM_BIT] |=> (mode == M_CPWM) && center_pwm)
    else $error("center select did not force center PWM");

  cpwm_down_a: // RQ18
    assert property ((mode == M_CPWM) && hit && cnt_down |=> pin_out != $past(q.elsa))
    else $error("center PWM down-count level wrong");

  irq_polled_a: // RQ8
    assert property (wr_csc && !hwdata[IE_BIT] |=> !irq)
    else $error("interrupt request with enable cleared");

  flag_clear_a: // RQ5
    assert property (clr && !ev |=> !q.flag)
    else $error("read then write zero did not clear flag");

  read_arms_a: // RQ5
    assert property (rd_csc && (ev || (q.flag && !clr)) |=> q.arm)
    else $error("read of set flag did not arm the clear");

  pin_free_a: // RQ12
    assert property ((mode == M_IC) || (els == ELS_OFF) |-> !pin_oe)
    else $error("pin driven in capture mode or with edge/level off");

  fall_only_a: // RQ13
    assert property ((mode == M_IC) && (els == ELS_FALL) && rise && !fall |-> !cap_ev)
    else $error("rising edge captured in falling mode");

  both_edges_a: // RQ13
    assert property ((mode == M_IC) && (els == ELS_BOTH) && (rise || fall) |=> q.flag)
    else $error("edge missed in both-edge capture");

  // Pin checks look one edge after the match or wrap, where the new level stands
  oc_clear_a: // RQ14
    assert property ((mode == M_OC) && (els == ELS_CLR) && hit |=> !pin_out)
    else $error("compare clear missing");

  oc_set_a: // RQ14
    assert property ((mode == M_OC) && (els == ELS_SET) && hit |=> pin_out)
    else $error("compare set missing");

  oc_soft_a: // RQ14
    assert property ((mode == M_OC) && (els == ELS_OFF) && hit |=> $stable(pin_out) && q.flag)
    else $error("software compare changed pin or missed flag");

  epwm_low_a: // RQ15
    assert property ((mode == M_EPWM) && q.elsa && hit |=> pin_out)
    else $error("edge PWM did not set on match");

  epwm_wrap_a: // RQ15
    assert property ((mode == M_EPWM) && wrap && !hit |=> pin_out != $past(q.elsa))
    else $error("edge PWM period start level wrong");

  capture_c: cover property (cap_ev ##1 q.flag);
  ic_both_c: cover property ((mode == M_IC) && (els == ELS_BOTH) && fall);
  clear_c: cover property (q.arm ##[1:4] clr ##1 !q.flag);
  race_c: cover property (ev && clr);
  cpwm_c: cover property ((mode == M_CPWM) && hit && cnt_down);

endmodule : tpmcc_channel

// ---- testbench/tpmcc_pin_model.sv ----
// Purpose: Far-side model of the channel pin.
// Assumes: No pull on the pin; the bench supplies the outside level.
// Notes:   While the block drives, the pin reads back its own level.
`timescale 1ns/1ps
module tpmcc_pin_model (
  // Block side
  input  wire logic pin_oe,
  input  wire logic pin_out,
  // Outside source
  input  wire logic ext_lvl,
  output logic      pin_in
);
  // Outside source yields only while the block drives
  assign pin_in = pin_oe ? pin_out : ext_lvl;
endmodule : tpmcc_pin_model

// ---- testbench/tpmcc_channel_tb_top.sv ----
// Purpose: Self-checking bench for the channel mode control block.
// Assumes: One AHB-Lite slave, so hready is its own hreadyout.
// Notes:   Counter inputs are driven here in place of the counter.
`timescale 1ns/1ps
module tpmcc_channel_tb_top;
  import tpmcc_pkg::*;
  logic        hclk, hready, hresp, center_pwm, pin_in, pin_out, pin_oe, irq;
  logic        hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        cnt_tick = 1'b0, cnt_down = 1'b0, ext_lvl = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata, rd;
  logic [15:0] cnt_value = 16'h0, cnt_mod = 16'h0, ch_value = 16'h0040;
  logic [7:0]  oc_cfg [4] = '{8'h1C, 8'h18, 8'h14, 8'h14};
  logic        oc_pin [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  int          fails = 0, checked = 0;

  tpmcc_channel u_tpmcc_channel (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .cnt_value(cnt_value), .cnt_mod(cnt_mod),
    .cnt_tick(cnt_tick), .cnt_down(cnt_down), .ch_value(ch_value), .center_pwm(center_pwm),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
  tpmcc_pin_model u_tpmcc_pin_model (.pin_oe(pin_oe), .pin_out(pin_out), .ext_lvl(ext_lvl),
    .pin_in(pin_in));

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  // Bounded wait: the slave has no wait states, but a stuck hready must not hang
  task automatic rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    if (hready !== 1'b1) begin
      fails++;
      tally_and_finish();
    end
  endtask : rdy

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    rd = hrdata;
    // Outputs launched at this edge settle before any check reads them
    #1;
  endtask : bus

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %08h expected %08h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_bit(input logic got, input logic exp);
    chk_reg({31'h0, got}, {31'h0, exp});
  endtask : chk_bit

  // Counter step of one tick, then time for flag and pin to land
  task automatic tick(input logic [15:0] v, input logic dn);
    cnt_value <= v;
    cnt_down  <= dn;
    cnt_tick  <= 1'b1;
    @(posedge hclk);
    cnt_tick  <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask : tick

  // Synchroniser, filter and edge register take four edges
  task automatic drive(input logic l);
    ext_lvl <= l;
    repeat (8) @(posedge hclk);
  endtask : drive

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    bus(1'b0, CSC_OFF, 32'h0);
    chk_reg(rd, {24'h0, CSC_RST});
    bus(1'b0, CTL_OFF, 32'h0);
    chk_reg(rd, {24'h0, CTL_RST});
    bus(1'b1, 8'h08, 32'hFF);
    bus(1'b0, 8'h08, 32'h0);
    chk_reg(rd, 32'h0);
    chk_bit(hresp, 1'b0);
    done("reset");
    // Pin has been stable long before each switch into capture
    for (int e = 1; e < 4; e++) begin
      bus(1'b1, CSC_OFF, 32'h40 | (e << 2));
      drive(1'b1);
      bus(1'b0, CSC_OFF, 32'h0);
      chk_bit(rd[FLAG_BIT], e[0]);
      chk_bit(irq, e[0]);
      bus(1'b1, CSC_OFF, 32'h40 | (e << 2));
      bus(1'b0, CSC_OFF, 32'h0);
      chk_bit(rd[FLAG_BIT], 1'b0);
      drive(1'b0);
      bus(1'b0, CSC_OFF, 32'h0);
      chk_bit(rd[FLAG_BIT], e[1]);
    end
    done("capture");
    bus(1'b1, CSC_OFF, 32'hCC);
    bus(1'b1, CSC_OFF, 32'h4C);
    bus(1'b0, CSC_OFF, 32'h0);
    chk_bit(rd[FLAG_BIT], 1'b1);
    drive(1'b1);
    bus(1'b1, CSC_OFF, 32'h4C);
    bus(1'b0, CSC_OFF, 32'h0);
    chk_bit(rd[FLAG_BIT], 1'b1);
    bus(1'b1, CSC_OFF, 32'h0C);
    bus(1'b0, CSC_OFF, 32'h0);
    chk_reg(rd, 32'h0C);
    drive(1'b0);
    bus(1'b0, CSC_OFF, 32'h0);
    chk_reg(rd, 32'h8C);
    chk_bit(irq, 1'b0);
    // Edge lands in the data phase of the clearing write: the set must win
    ext_lvl <= 1'b1;
    repeat (3) @(posedge hclk);
    bus(1'b1, CSC_OFF, 32'h0C);
    bus(1'b0, CSC_OFF, 32'h0);
    chk_reg(rd, 32'h8C);
    bus(1'b1, CSC_OFF, 32'h0);
    done("clear");
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, CSC_OFF, {24'h0, oc_cfg[i]});
      chk_bit(pin_oe, 1'b1);
      tick(16'h0041, 1'b0);
      chk_bit(pin_out, !oc_pin[i]);
      tick(16'h0040, 1'b0);
      chk_bit(pin_out, oc_pin[i]);
    end
    bus(1'b0, CSC_OFF, 32'h0);
    chk_bit(rd[FLAG_BIT], 1'b1);
    bus(1'b1, CSC_OFF, 32'h10);
    chk_bit(pin_oe, 1'b0);
    tick(16'h0040, 1'b0);
    bus(1'b0, CSC_OFF, 32'h0);
    chk_bit(rd[FLAG_BIT], 1'b1);
    done("compare");
    for (int a = 0; a < 2; a++) begin
      bus(1'b1, CSC_OFF, 32'h28 + 12 * a);
      tick(16'h0040, 1'b0);
      chk_bit(pin_out, a[0]);
      tick(16'h0000, 1'b0);
      chk_bit(pin_out, !a[0]);
    end
    bus(1'b0, CSC_OFF, 32'h0);
    bus(1'b1, CSC_OFF, 32'h34);
    ch_value <= 16'h0000;
    tick(16'h0000, 1'b0);
    ch_value <= 16'h0050;
    cnt_mod  <= 16'h0040;
    tick(16'h0050, 1'b0);
    bus(1'b0, CSC_OFF, 32'h0);
    chk_bit(rd[FLAG_BIT], 1'b0);
    done("edge pwm");
    ch_value <= 16'h0040;
    cnt_mod  <= 16'h0000;
    bus(1'b1, CTL_OFF, 32'h1);
    chk_bit(center_pwm, 1'b1);
    for (int a = 0; a < 2; a++) begin
      bus(1'b1, CSC_OFF, 32'h08 >> a);
      tick(16'h0040, 1'b0);
      chk_bit(pin_out, a[0]);
      tick(16'h0040, 1'b1);
      chk_bit(pin_out, !a[0]);
    end
    bus(1'b0, CSC_OFF, 32'h0);
    chk_bit(rd[FLAG_BIT], 1'b1);
    bus(1'b1, CTL_OFF, 32'h0);
    chk_bit(center_pwm, 1'b0);
    done("center pwm");
    tally_and_finish();
  end
endmodule : tpmcc_channel_tb_top
